/* dv/cise_bus_host_model.sv */
/*
 * far side of the encoder: can bus activity on the wake pin and the
 * host handler that clears the wake flag itself.
 * assumes the bench pulses burstGo and raises ackWake when wanted.
 */
`timescale 1ns/10ps

module cise_bus_host_model (
    input wire logic ref_clk,
    input wire logic burstGo,
    input wire logic ackWake,
    input wire cise_pkg::cise_src_t srcFlag,
    output logic busActivity,
    output logic wakeClr
);
    import cise_pkg::*;

    // ************************************************************
    // bus activity, off the clock phase on purpose
    // ************************************************************
    initial begin
        busActivity = 1'b0;
        forever begin
            @(posedge burstGo);
            #3 busActivity = 1'b1;
            #24 busActivity = 1'b0;
        end
    end

    // host clears the wake flag only when told to service it
    initial wakeClr = 1'b0;
    always @(posedge ref_clk) begin
        wakeClr <= ackWake && srcFlag[6] && !wakeClr;
    end
endmodule

/* dv/cise_top_test.sv */
/*
 * self-checking bench of the encoder with a flag model in the bench.
 * assumes the design package and the bus and host model.
 */
`timescale 1ns/10ps

module cise_top_test;
    import cise_pkg::*;
    logic ref_clk, rst_n, sleepMode, burstGo, ackWake, busAct, wakeClr;
    logic irqReq, wakeReq, mErr;
    cise_src_t en, clr, flags, mFlag;
    logic [1:0] ovClr, rxL, accBuf, rxFull;
    logic [2:0] txE, code;
    logic [8:0] rxCnt, txCnt;
    logic [4:0] prev;
    logic [31:0] lfsr, r;
    cise_comm_status_t stat;
    int failures, totalChecks;
    int rxv[8] = '{95, 96, 128, 0, 0, 0, 0, 0};
    int txv[8] = '{0, 0, 0, 96, 128, 255, 256, 0};
    logic [4:0] es[8] = '{5'h00, 5'h10, 5'h14, 5'h08, 5'h0a, 5'h0a,
        5'h0b, 5'h00};

    cise_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .srcEnable(en),
        .hostClear(clr | {1'b0, wakeClr, 6'h00}), .ovflClear(ovClr),
        .txBufEmpty(txE), .rxBufLoaded(rxL), .msgError(mErr),
        .rxAcceptBuf(accBuf), .rxBufFull(rxFull), .sleepMode(sleepMode),
        .busActivity(busAct), .rxErrCount(rxCnt), .txErrCount(txCnt),
        .srcFlag_r(flags), .commStatus_r(stat), .irqPriorityCode_r(code),
        .irqRequest_r(irqReq), .wakeRequest_r(wakeReq));
    cise_bus_host_model u_far (.ref_clk(ref_clk), .burstGo(burstGo),
        .ackWake(ackWake), .srcFlag(flags), .busActivity(busAct),
        .wakeClr(wakeClr));

    // ************************************************************
    // helpers
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] nxt(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // error first, then tx0..tx2, rx0, rx1, wake; msg bit never coded
    function automatic logic [2:0] code_of(logic [7:0] t);
        if (t[0]) return 3'h1;
        if (t[1]) return 3'h4;
        if (t[2]) return 3'h3;
        if (t[3]) return 3'h2;
        if (t[4]) return 3'h6;
        if (t[5]) return 3'h5;
        if (t[6]) return 3'h7;
        return 3'h0;
    endfunction

    task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task report_and_stop;
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        #100000;
        failures++;
        report_and_stop;
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {rst_n, sleepMode, burstGo, ackWake, mErr} = '0;
        {en, clr, mFlag, ovClr, rxL, accBuf, rxFull, txE} = '0;
        {rxCnt, txCnt, prev} = '0;
        lfsr = 32'h27fc3980;
        tick(5);
        chk("rstFlags", {code, irqReq, flags}, 16'h0000);
        rst_n = 1'b1;
        // random events, enables and clears against the flag model
        for (int i = 0; i < 300; i++) begin
            lfsr = nxt(lfsr);
            r = lfsr;
            lfsr = nxt(lfsr);
            en = r[7:0];
            clr = (i == 299) ? 8'hff : r[15:8] & r[23:16] & lfsr[7:0];
            txE = (i == 299) ? 3'h0 : r[26:24] & r[29:27];
            rxL = (i == 299) ? 2'h0 : r[31:30] & lfsr[9:8];
            mErr = (i != 299) && lfsr[10] && lfsr[11];
            tick(1);
            mFlag = (mFlag & ~clr) | {mErr, 1'b0, rxL, txE, 1'b0};
            chk("flags", flags, mFlag);
            chk("code", code, code_of(mFlag & en));
            chk("irq", irqReq, |(mFlag & en));
        end
        {en, txE, rxL, mErr, clr} = {8'hff, 14'h0000};
        // counter thresholds and the error flag on each state change
        for (int i = 0; i < 8; i++) begin
            rxCnt = 9'(rxv[i]);
            txCnt = 9'(txv[i]);
            tick(4);
            chk("status", stat[4:0], es[i]);
            chk("errFlag", flags[0], es[i] != prev);
            chk("errCode", code, (es[i] != prev) ? 3'h1 : 3'h0);
            prev = es[i];
            clr[0] = 1'b1;
            tick(1);
            clr[0] = 1'b0;
            tick(1);
            chk("errClr", flags[0], 1'b0);
        end
        // accepted message into a free buffer, then into a full one
        rxFull = 2'b01;
        accBuf = 2'b10;
        tick(1);
        accBuf = 2'b01;
        tick(1);
        accBuf = 2'b00;
        tick(3);
        chk("ovfl", {stat[6:5], flags[0]}, 3'b011);
        clr[0] = 1'b1;
        tick(1);
        clr[0] = 1'b0;
        tick(12);
        chk("ovflHeld", {stat[6:5], flags[0]}, 3'b011);
        ovClr = 2'b01;
        tick(1);
        ovClr = 2'b00;
        clr[0] = 1'b1;
        tick(1);
        clr[0] = 1'b0;
        tick(2);
        chk("ovflClr", {stat[6:5], flags[0]}, 3'b000);
        // wake from sleep, held until the host clears it
        sleepMode = 1'b1;
        burstGo = 1'b1;
        tick(12);
        burstGo = 1'b0;
        chk("wake", {flags[6], wakeReq, code}, 5'b11111);
        tick(20);
        chk("wakeHeld", flags[6], 1'b1);
        ackWake = 1'b1;
        tick(4);
        chk("wakeClr", {flags[6], irqReq}, 2'b00);
        sleepMode = 1'b0;
        burstGo = 1'b1;
        tick(12);
        chk("awake", {flags[6], wakeReq}, 2'b00);
        report_and_stop;
    end
endmodule

/* logic/cise_err_state.sv */
/*
 * error state decoder: warning, passive and bus-off from the counters.
 * assumes the counters come from the protocol engine on ref_clk.
 */
`timescale 1ns/10ps
`include "cise_regs.svh"

module cise_err_state (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [8:0] rxErrCount,
    input wire logic [8:0] txErrCount,
    output logic rxWarn_r,
    output logic txWarn_r,
    output logic rxPassive_r,
    output logic txPassive_r,
    output logic busOff_r
);

    // all checks here share the one clock and the reset
    default clocking cb_err @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ************************************************************
    // threshold compare, registered
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rxWarn_r <= 1'b0;
            txWarn_r <= 1'b0;
            rxPassive_r <= 1'b0;
            txPassive_r <= 1'b0;
            busOff_r <= 1'b0;
        end else begin
            rxWarn_r <= rxErrCount >= `CISE_WARN_LIMIT;
            txWarn_r <= txErrCount >= `CISE_WARN_LIMIT;
            rxPassive_r <= rxErrCount > `CISE_PASSIVE_LIMIT;
            txPassive_r <= txErrCount > `CISE_PASSIVE_LIMIT;
            busOff_r <= txErrCount > `CISE_BUSOFF_LIMIT;
        end
    end

    a_warn_level: assert property (rxErrCount >= 9'h060 |=> rxWarn_r)
        else $error("rx warning missed");
    a_busoff_level: assert property (
        txErrCount == 9'h100 |=> busOff_r && txPassive_r)
        else $error("bus-off missed");

endmodule

/* logic/cise_pkg.sv */
/*
 * types of the can interrupt status encoder.
 * assumes the constants header sits beside it.
 */
`include "cise_regs.svh"

package cise_pkg;

    // ************************************************************
    // carriers
    // ************************************************************
    // one bit per source, positions as the header gives them
    typedef logic [`CISE_NSRC-1:0] cise_src_t;

    // error status bits read by the host
    typedef struct packed {
        logic rxOverflow1;
        logic rxOverflow0;
        logic rxWarn;
        logic txWarn;
        logic rxPassive;
        logic txPassive;
        logic busOff;
    } cise_comm_status_t;

endpackage

/* logic/cise_regs.svh */
/*
 * constants of the can interrupt status encoder: priority codes, error
 * counter limits and flag positions.
 * assumes inclusion by bare name from the package and design files.
 */
`ifndef CISE_REGS_SVH
`define CISE_REGS_SVH

// ****************************************************************
// priority codes
// ****************************************************************
`define CISE_CODE_NONE 3'h0
`define CISE_CODE_ERR 3'h1
`define CISE_CODE_TX2 3'h2
`define CISE_CODE_TX1 3'h3
`define CISE_CODE_TX0 3'h4
`define CISE_CODE_RX1 3'h5
`define CISE_CODE_RX0 3'h6
`define CISE_CODE_WAK 3'h7

// ****************************************************************
// error counter limits
// ****************************************************************
`define CISE_WARN_LIMIT 9'h060
`define CISE_PASSIVE_LIMIT 9'h07f
`define CISE_BUSOFF_LIMIT 9'h0ff

// ****************************************************************
// source positions in the flag vector
// ****************************************************************
`define CISE_SRC_ERR 0
`define CISE_SRC_TX0 1
`define CISE_SRC_TX1 2
`define CISE_SRC_TX2 3
`define CISE_SRC_RX0 4
`define CISE_SRC_RX1 5
`define CISE_SRC_WAK 6
`define CISE_SRC_MSG 7
`define CISE_NSRC 8

`endif

/* logic/cise_top.sv */
/*
 * can interrupt status encoder: sticky source flags, enables, 3-bit
 * priority code, error status flags and combined interrupt request.
 * assumes protocol-engine events are one-cycle pulses on ref_clk and
 * host clears are one-cycle pulses on ref_clk; busActivity is a pin.
 */
`timescale 1ns/10ps
`include "cise_regs.svh"

// Functional notes
// - code 0 none, 1 error, 2..4 tx buffers 2..0, 5..6 rx 1..0, 7 wake.
// - message errors set the message-error flag; enabled, it interrupts.
// - asleep with wake enabled, bus activity sets wake and raises the wake request.
// - overflow or error-state change sets the error flag; status tells.
// - accepted message with its receive buffer full sets its overflow bit.
// - receive warning when the receive error count reaches 96.
// - transmit warning when the transmit error count reaches 96.
// - count above 127 gives the matching passive flag.
// - transmit count above 255 gives bus-off.
// - interrupt stays pending while any of its enabled flags is set.
// - host clears are ignored while the cause is still present.
// - once the top source clears, the code moves to the next one.
// - a transmit buffer going empty sets its flag.
// - a receive buffer loaded at end of frame sets its flag.
module cise_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire cise_pkg::cise_src_t srcEnable,
    input wire cise_pkg::cise_src_t hostClear,
    input wire logic [1:0] ovflClear,
    input wire logic [2:0] txBufEmpty,
    input wire logic [1:0] rxBufLoaded,
    input wire logic msgError,
    input wire logic [1:0] rxAcceptBuf,
    input wire logic [1:0] rxBufFull,
    input wire logic sleepMode,
    input wire logic busActivity,
    input wire logic [8:0] rxErrCount,
    input wire logic [8:0] txErrCount,
    output cise_pkg::cise_src_t srcFlag_r,
    output cise_pkg::cise_comm_status_t commStatus_r,
    output logic [2:0] irqPriorityCode_r,
    output logic irqRequest_r,
    output logic wakeRequest_r
);
    import cise_pkg::*;

    // all checks below share the one clock and the reset
    default clocking cb_top @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ************************************************************
    // pin synchroniser for bus activity
    // ************************************************************
    logic [2:0] actSync_r;
    logic actLevel_r;
    logic actRise;

    // a change counts once the second and third stages agree
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            actSync_r <= 3'h0;
            actLevel_r <= 1'b0;
        end else begin
            actSync_r <= {actSync_r[1:0], busActivity};
            if (actSync_r[1] == actSync_r[2]) begin
                actLevel_r <= actSync_r[2];
            end
        end
    end
    assign actRise = (actSync_r[1] == actSync_r[2]) && actSync_r[2] &&
        !actLevel_r;

    // ************************************************************
    // error state decode
    // ************************************************************
    logic rxWarn;
    logic txWarn;
    logic rxPassive;
    logic txPassive;
    logic busOff;

    cise_err_state u_err_state (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .rxErrCount(rxErrCount),
        .txErrCount(txErrCount),
        .rxWarn_r(rxWarn),
        .txWarn_r(txWarn),
        .rxPassive_r(rxPassive),
        .txPassive_r(txPassive),
        .busOff_r(busOff)
    );

    // ************************************************************
    // receive overflow bits
    // ************************************************************
    logic [1:0] ovflSet;
    logic [1:0] ovflNxt;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ovfl
            assign ovflSet[gi] = rxAcceptBuf[gi] && rxBufFull[gi];
            // set beats a same-cycle clear so no overflow is lost
            assign ovflNxt[gi] = ovflSet[gi] ||
                (commStatus_r[5+gi] && !ovflClear[gi]);
        end
    endgenerate

    // ************************************************************
    // error status register and change detect
    // ************************************************************
    logic [4:0] stateNow;
    logic [4:0] stateOld_r;
    logic stateChange;

    assign stateNow = {rxWarn, txWarn, rxPassive, txPassive, busOff};
    assign stateChange = stateNow != stateOld_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            commStatus_r <= '0;
            stateOld_r <= 5'h0;
        end else begin
            commStatus_r <= {ovflNxt, stateNow};
            stateOld_r <= stateNow;
        end
    end

    // ************************************************************
    // sticky source flags
    // ************************************************************
    cise_src_t setEvt;
    cise_src_t hold;
    cise_src_t flagNxt;

    // one set term per source
    always_comb begin
        setEvt = '0;
        setEvt[`CISE_SRC_ERR] = stateChange || (|ovflSet);
        setEvt[`CISE_SRC_TX0] = txBufEmpty[0];
        setEvt[`CISE_SRC_TX1] = txBufEmpty[1];
        setEvt[`CISE_SRC_TX2] = txBufEmpty[2];
        setEvt[`CISE_SRC_RX0] = rxBufLoaded[0];
        setEvt[`CISE_SRC_RX1] = rxBufLoaded[1];
        setEvt[`CISE_SRC_WAK] = sleepMode && actRise &&
            srcEnable[`CISE_SRC_WAK];
        setEvt[`CISE_SRC_MSG] = msgError;
    end

    // a clear is refused while the cause still stands
    always_comb begin
        hold = '0;
        hold[`CISE_SRC_ERR] = |commStatus_r[6:5];
        hold[`CISE_SRC_TX0] = txBufEmpty[0];
        hold[`CISE_SRC_TX1] = txBufEmpty[1];
        hold[`CISE_SRC_TX2] = txBufEmpty[2];
    end

    // the wake flag is never dropped by the block itself
    assign flagNxt = setEvt | (srcFlag_r & ~(hostClear & ~hold));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            srcFlag_r <= '0;
        end else begin
            srcFlag_r <= flagNxt;
        end
    end

    // ************************************************************
    // priority encode and request
    // ************************************************************
    function automatic logic [2:0] encode(input cise_src_t act);
        logic [2:0] c;
        c = `CISE_CODE_NONE;
        if (act[`CISE_SRC_ERR]) c = `CISE_CODE_ERR;
        else if (act[`CISE_SRC_TX0]) c = `CISE_CODE_TX0;
        else if (act[`CISE_SRC_TX1]) c = `CISE_CODE_TX1;
        else if (act[`CISE_SRC_TX2]) c = `CISE_CODE_TX2;
        else if (act[`CISE_SRC_RX0]) c = `CISE_CODE_RX0;
        else if (act[`CISE_SRC_RX1]) c = `CISE_CODE_RX1;
        else if (act[`CISE_SRC_WAK]) c = `CISE_CODE_WAK;
        return c;
    endfunction

    cise_src_t active;
    assign active = flagNxt & srcEnable;

    // code and request follow the flags in the same edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irqPriorityCode_r <= `CISE_CODE_NONE;
            irqRequest_r <= 1'b0;
        end else begin
            irqPriorityCode_r <= encode(active);
            irqRequest_r <= |active;
        end
    end

    // wake request lasts while the wake flag is up and enabled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wakeRequest_r <= 1'b0;
        end else begin
            wakeRequest_r <= active[`CISE_SRC_WAK];
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_wake_evt;
        sleepMode && actRise && srcEnable[6];
    endsequence
    sequence s_wake_up;
        srcFlag_r[6] && wakeRequest_r;
    endsequence

    a_wake_sets: assert property (s_wake_evt |=> s_wake_up)
        else $error("wake not raised");
    a_wake_sticky: assert property (
        srcFlag_r[6] && !hostClear[6] |=> srcFlag_r[6])
        else $error("wake dropped by itself");
    a_ovfl_sticky: assert property (
        commStatus_r[5] && !ovflClear[0] |=> commStatus_r[5])
        else $error("overflow dropped");
    a_ovfl_sets: assert property (
        rxAcceptBuf[0] && rxBufFull[0] |=> commStatus_r[5] && srcFlag_r[0])
        else $error("overflow not flagged");
    a_msg_irq: assert property (
        msgError && srcEnable[7] |=> srcFlag_r[7] && irqRequest_r)
        else $error("message error missed");
    a_err_hold: assert property (
        srcFlag_r[0] && (|commStatus_r[6:5]) |=> srcFlag_r[0])
        else $error("error flag cleared early");
    a_code_err: assert property (
        srcFlag_r[0] && srcEnable[0] && !hostClear[0]
        |=> irqPriorityCode_r == 3'h1)
        else $error("error code wrong");
    a_tx0_code: assert property (
        txBufEmpty[0] && srcEnable[1] && !srcFlag_r[0] && !srcEnable[0]
        |=> irqPriorityCode_r == 3'h4)
        else $error("tx0 code wrong");
    // message errors carry no code, so they may request on their own
    a_none_code: assert property (
        irqPriorityCode_r == 3'h0 && !srcFlag_r[7] |-> !irqRequest_r)
        else $error("request without code");
    a_rx_flag: assert property (rxBufLoaded[0] |=> srcFlag_r[4])
        else $error("rx0 flag missed");

endmodule
